// file: hdl/sec_pkg.sv
// Constants, types and frame builder for the serial EEPROM controller
package sec_pkg;
  localparam logic [7:0] SIG_VALUE = 8'ha5;
  localparam logic [6:0] SIG_LOC = 7'h00;
  localparam logic [2:0] LAST_BYTE = 3'h5;
  localparam int CLK_MHZ = 100;
  localparam int SK_HALF_NS = 500;
  localparam int SK_HALF_CYCLES = (SK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int TIMEOUT_MS = 30;
  localparam int TIMEOUT_CYCLES = TIMEOUT_MS * CLK_MHZ * 1000;
  localparam logic [4:0] SHORT_BITS = 5'h0a;
  localparam logic [4:0] LONG_BITS = 5'h12;
  // APB byte offsets
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] DATA_OFS = 8'h04;
  localparam logic [7:0] STA_LO_OFS = 8'h08;
  localparam logic [7:0] STA_HI_OFS = 8'h0c;
  localparam logic [7:0] PIN_OFS = 8'h10;
  // Command register fields
  localparam int BUSY_BIT = 31;
  localparam int CODE_MSB = 30;
  localparam int CODE_LSB = 28;
  localparam int TO_BIT = 9;
  localparam int LOADED_BIT = 8;
  localparam int ADDR_MSB = 6;
  // Pin configuration fields
  localparam int PIN_DIS_BIT = 0;
  localparam int PIN_MON_BIT = 1;
  localparam int GPO_DATA_BIT = 2;
  localparam int GPO_CLK_BIT = 3;
  localparam int SOFT_RST_BIT = 8;
  // Serial opcodes
  localparam logic START_BIT = 1'b1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] OP_SPECIAL = 2'h0;
  localparam logic [1:0] SUB_ERASE_WRITE_ENABLE_CMD = 2'h3;
  localparam logic [1:0] SUB_ERASE_WRITE_DISABLE_CMD = 2'h0;
  localparam logic [1:0] SUB_ERASE_ALL_CMD = 2'h2;
  localparam logic [1:0] SUB_WRITE_ALL_CMD = 2'h1;

  typedef enum logic [2:0] {
    CMD_READ, CMD_ERASE_WRITE_DISABLE_CMD, CMD_ERASE_WRITE_ENABLE_CMD, CMD_WRITE,
    CMD_WRITE_ALL_CMD, CMD_ERASE, CMD_ERASE_ALL_CMD, CMD_RELOAD
  } sec_cmd_t;

  typedef struct packed {
    logic [17:0] bits;
    logic [4:0] len;
    logic rd;
    logic poll;
  } sec_frame_t;

  typedef struct packed {
    logic cs;
    logic sk;
    logic dout;
    logic oe;
  } sec_pins_t;

  // Left-aligned frame, start bit first
  function automatic sec_frame_t sec_build(input sec_cmd_t cmd,
      input logic [6:0] addr, input logic [7:0] data);
    sec_frame_t f;
    logic [1:0] op;
    logic [6:0] a;
    f = '0;
    op = OP_SPECIAL;
    a = addr;
    f.len = SHORT_BITS;
    unique case (cmd)
      CMD_READ, CMD_RELOAD: begin
        op = OP_READ;
        f.len = LONG_BITS;
        f.rd = 1'b1;
      end
      CMD_WRITE: begin
        op = OP_WRITE;
        f.len = LONG_BITS;
        f.poll = 1'b1;
      end
      CMD_ERASE: begin
        op = OP_ERASE;
        f.poll = 1'b1;
      end
      CMD_WRITE_ALL_CMD: begin
        a = {SUB_WRITE_ALL_CMD, 5'h00};
        f.len = LONG_BITS;
        f.poll = 1'b1;
      end
      CMD_ERASE_ALL_CMD: begin
        a = {SUB_ERASE_ALL_CMD, 5'h00};
        f.poll = 1'b1;
      end
      CMD_ERASE_WRITE_ENABLE_CMD: a = {SUB_ERASE_WRITE_ENABLE_CMD, 5'h00};
      CMD_ERASE_WRITE_DISABLE_CMD: a = {SUB_ERASE_WRITE_DISABLE_CMD, 5'h00};
    endcase
    f.bits = {START_BIT, op, a, data};
    return f;
  endfunction : sec_build
endpackage : sec_pkg

// file: hdl/sec_serial.sv
// Three-wire serial shifter with ready polling
module sec_serial (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire sec_pkg::sec_frame_t frame,
  input wire logic abort,
  input wire logic din,
  output logic done,
  output logic [7:0] rx_byte,
  output sec_pkg::sec_pins_t pins
);
  typedef enum logic [1:0] {S_IDLE, S_SHIFT, S_GAP, S_POLL} sec_sst_t;
  localparam logic [6:0] HALF_LAST = 7'(sec_pkg::SK_HALF_CYCLES - 1);
  localparam logic [4:0] CMD_BITS = sec_pkg::SHORT_BITS;

  sec_sst_t state;
  logic [6:0] hcnt;
  logic tick;
  logic [17:0] sh;
  logic [4:0] sent;
  logic [4:0] len;
  logic rd;
  logic poll;
  logic [2:0] sync;
  logic din_q;

  assign tick = (hcnt == HALF_LAST);

  // Only the agreeing later stages are looked at
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync <= 3'h0;
      din_q <= 1'b0;
    end else begin
      sync <= {sync[1:0], din};
      if (sync[1] == sync[2]) begin
        din_q <= sync[2];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hcnt <= 7'h00;
    end else if (state == S_IDLE || start || tick) begin
      hcnt <= 7'h00;
    end else begin
      hcnt <= hcnt + 7'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      pins <= '0;
      sh <= 18'h00000;
      sent <= 5'h00;
      len <= 5'h00;
      rd <= 1'b0;
      poll <= 1'b0;
      done <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      done <= 1'b0;
      if (abort) begin
        state <= S_IDLE;
        pins <= '0;
      end else begin
        unique case (state)
          S_IDLE: begin
            if (start) begin
              sh <= {frame.bits[16:0], 1'b0};
              pins <= '{cs: 1'b1, sk: 1'b0, dout: frame.bits[17],
                        oe: 1'b1};
              sent <= 5'h00;
              len <= frame.len;
              rd <= frame.rd;
              poll <= frame.poll;
              state <= S_SHIFT;
            end
          end
          S_SHIFT: begin
            if (tick && !pins.sk) begin
              pins.sk <= 1'b1;
              rx_byte <= {rx_byte[6:0], din_q};
            end else if (tick) begin
              pins.sk <= 1'b0;
              sent <= sent + 5'h01;
              pins.dout <= sh[17];
              sh <= {sh[16:0], 1'b0};
              // Read data phase: release the line
              pins.oe <= !(rd && (sent + 5'h01 >= CMD_BITS));
              if (sent + 5'h01 == len) begin
                pins <= '0;
                state <= poll ? S_GAP : S_IDLE;
                done <= !poll;
              end
            end
          end
          S_GAP: begin
            if (tick) begin
              pins.cs <= 1'b1;
              state <= S_POLL;
            end
          end
          S_POLL: begin
            // Busy shows low on the line until programmed
            if (tick && din_q) begin
              pins.cs <= 1'b0;
              done <= 1'b1;
              state <= S_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule : sec_serial

// file: hdl/sec_ctrl.sv
// Serial EEPROM controller top with APB registers
// Operation
// - After any reset read location 00h; present only if it holds A5h.
// - On match read next six bytes into station address, byte 0 first.
// - After six bytes set the address-loaded flag.
// - Bad signature stops loading; station address untouched, flag clear.
// - Reload command repeats signature check and load; fails without A5h.
// - Successful reload sets the load-success flag.
// - Setting busy starts a command; busy clears when it finishes.
// - Read places the addressed byte into the data register.
// - No response within 30ms abandons the command and sets timeout.
// - Erase clears the single addressed location.
// - Erase-all starts a bulk erase of the whole array.
// - Write stores the data byte at the addressed location.
// - Write-all stores the data byte in every location.
// - Ten serial clocks for short commands, eighteen for data ones.
// - Memory is 128 bytes, seven-bit location address.
// - With the interface disabled the pins serve as outputs or monitors.
module sec_ctrl #(
  parameter int TIMEOUT_CYCLES = sec_pkg::TIMEOUT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] media_monitor,
  input wire logic serial_memory_data_pin_in,
  output logic serial_memory_data_pin_out,
  output logic serial_memory_data_pin_oe,
  output logic serial_memory_clock_pin,
  output logic serial_memory_select_pin,
  output logic [47:0] station_address
);
  typedef enum logic [1:0] {ST_IDLE, ST_SIG, ST_ADDR, ST_CMD} sec_st_t;
  localparam logic [21:0] TO_LAST = 22'(TIMEOUT_CYCLES - 1);

  sec_st_t state;
  logic command_busy_flag;
  logic response_timeout_flag;
  logic station_addr_loaded_flag;
  sec_pkg::sec_cmd_t command_code_field;
  logic [6:0] location_address_field;
  logic [7:0] eeprom_byte_reg;
  logic [31:0] station_address_low;
  logic [15:0] station_address_high;
  logic [3:0] pin_cfg;
  logic load_pending;
  logic [2:0] idx;
  logic [21:0] tcnt;
  logic to_hit;
  logic ser_start;
  sec_pkg::sec_frame_t ser_frame;
  logic ser_done;
  logic [7:0] ser_rx;
  sec_pkg::sec_pins_t ser_pins;
  logic wr_en;
  logic rd_setup;
  logic cmd_go;
  logic byte_ev;
  logic load_ok;
  logic read_ok;
  logic load_start;

  function automatic logic mapped(input logic [7:0] a);
    return a == sec_pkg::CMD_OFS || a == sec_pkg::DATA_OFS ||
           a == sec_pkg::STA_LO_OFS || a == sec_pkg::STA_HI_OFS ||
           a == sec_pkg::PIN_OFS;
  endfunction : mapped

  assign wr_en = psel && penable && pready && pwrite && mapped(paddr);
  assign rd_setup = psel && !penable && !pready;
  assign cmd_go = wr_en && paddr == sec_pkg::CMD_OFS &&
                  pwdata[sec_pkg::BUSY_BIT] && !command_busy_flag;
  assign to_hit = (state != ST_IDLE) && (tcnt == TO_LAST);
  assign byte_ev = (state == ST_ADDR) && ser_done;
  assign load_ok = byte_ev && idx == sec_pkg::LAST_BYTE;
  assign read_ok = (state == ST_CMD) && ser_done &&
                   command_code_field == sec_pkg::CMD_READ;
  assign load_start = (state == ST_IDLE) && !command_busy_flag &&
                      load_pending;

  sec_serial u_serial (
    .pclk(pclk),
    .presetn(presetn),
    .start(ser_start),
    .frame(ser_frame),
    .abort(to_hit),
    .din(serial_memory_data_pin_in),
    .done(ser_done),
    .rx_byte(ser_rx),
    .pins(ser_pins)
  );

  // APB: one wait-free access phase, data ready at its first edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= rd_setup;
      pslverr <= rd_setup && !mapped(paddr);
      prdata <= 32'h00000000;
      if (rd_setup && !pwrite) begin
        unique case (paddr)
          sec_pkg::CMD_OFS: begin
            prdata[sec_pkg::BUSY_BIT] <= command_busy_flag;
            prdata[sec_pkg::CODE_MSB:sec_pkg::CODE_LSB] <=
              command_code_field;
            prdata[sec_pkg::TO_BIT] <= response_timeout_flag;
            prdata[sec_pkg::LOADED_BIT] <= station_addr_loaded_flag;
            prdata[sec_pkg::ADDR_MSB:0] <= location_address_field;
          end
          sec_pkg::DATA_OFS: prdata[7:0] <= eeprom_byte_reg;
          sec_pkg::STA_LO_OFS: prdata <= station_address_low;
          sec_pkg::STA_HI_OFS: prdata[15:0] <= station_address_high;
          sec_pkg::PIN_OFS: prdata[3:0] <= pin_cfg;
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Fields are frozen while busy, so a late write cannot skew a command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      command_code_field <= sec_pkg::CMD_READ;
      location_address_field <= 7'h00;
    end else if (cmd_go) begin
      command_code_field <= sec_pkg::sec_cmd_t'(
        pwdata[sec_pkg::CODE_MSB:sec_pkg::CODE_LSB]);
      location_address_field <= pwdata[sec_pkg::ADDR_MSB:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_pending <= 1'b1;
    end else if (wr_en && paddr == sec_pkg::PIN_OFS &&
                 pwdata[sec_pkg::SOFT_RST_BIT]) begin
      load_pending <= 1'b1;
    end else if (load_start) begin
      load_pending <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_cfg <= 4'h0;
    end else if (wr_en && paddr == sec_pkg::PIN_OFS) begin
      pin_cfg <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcnt <= 22'h000000;
    end else if (state == ST_IDLE || ser_start) begin
      tcnt <= 22'h000000;
    end else begin
      tcnt <= tcnt + 22'h000001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      command_busy_flag <= 1'b0;
      idx <= 3'h0;
      ser_start <= 1'b0;
      ser_frame <= '0;
    end else begin
      ser_start <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (load_start || (cmd_go && sec_pkg::sec_cmd_t'(
              pwdata[sec_pkg::CODE_MSB:sec_pkg::CODE_LSB]) ==
              sec_pkg::CMD_RELOAD)) begin
            command_busy_flag <= 1'b1;
            ser_frame <= sec_pkg::sec_build(sec_pkg::CMD_READ,
                                            sec_pkg::SIG_LOC, 8'h00);
            ser_start <= 1'b1;
            state <= ST_SIG;
          end else if (cmd_go) begin
            command_busy_flag <= 1'b1;
            ser_frame <= sec_pkg::sec_build(sec_pkg::sec_cmd_t'(
                pwdata[sec_pkg::CODE_MSB:sec_pkg::CODE_LSB]),
                pwdata[sec_pkg::ADDR_MSB:0], eeprom_byte_reg);
            ser_start <= 1'b1;
            state <= ST_CMD;
          end
        end
        ST_SIG: begin
          if (to_hit) begin
            command_busy_flag <= 1'b0;
            state <= ST_IDLE;
          end else if (ser_done && ser_rx == sec_pkg::SIG_VALUE) begin
            idx <= 3'h0;
            ser_frame <= sec_pkg::sec_build(sec_pkg::CMD_READ,
                                            7'h01, 8'h00);
            ser_start <= 1'b1;
            state <= ST_ADDR;
          end else if (ser_done) begin
            command_busy_flag <= 1'b0;
            state <= ST_IDLE;
          end
        end
        ST_ADDR: begin
          if (to_hit || load_ok) begin
            command_busy_flag <= 1'b0;
            state <= ST_IDLE;
          end else if (byte_ev) begin
            idx <= idx + 3'h1;
            ser_frame <= sec_pkg::sec_build(sec_pkg::CMD_READ,
                                            7'({idx, 1'b0} >> 1) + 7'h02,
                                            8'h00);
            ser_start <= 1'b1;
          end
        end
        ST_CMD: begin
          if (to_hit || ser_done) begin
            command_busy_flag <= 1'b0;
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eeprom_byte_reg <= 8'h00;
    end else if (read_ok) begin
      eeprom_byte_reg <= ser_rx;
    end else if (wr_en && paddr == sec_pkg::DATA_OFS) begin
      eeprom_byte_reg <= pwdata[7:0];
    end
  end

  // byte 0 low first; loader beats a host write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      station_address_low <= 32'h00000000;
      station_address_high <= 16'h0000;
    end else if (byte_ev) begin
      unique case (idx)
        3'h0: station_address_low[7:0] <= ser_rx;
        3'h1: station_address_low[15:8] <= ser_rx;
        3'h2: station_address_low[23:16] <= ser_rx;
        3'h3: station_address_low[31:24] <= ser_rx;
        3'h4: station_address_high[7:0] <= ser_rx;
        3'h5: station_address_high[15:8] <= ser_rx;
        default: station_address_high <= station_address_high;
      endcase
    end else if (wr_en && paddr == sec_pkg::STA_LO_OFS) begin
      station_address_low <= pwdata;
    end else if (wr_en && paddr == sec_pkg::STA_HI_OFS) begin
      station_address_high <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      station_address <= 48'h000000000000;
    end else begin
      station_address <= {station_address_high, station_address_low};
    end
  end

  // loaded flag; cleared when the signature read completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      station_addr_loaded_flag <= 1'b0;
    end else if (load_ok) begin
      station_addr_loaded_flag <= 1'b1;
    end else if (state == ST_SIG && ser_done) begin
      station_addr_loaded_flag <= 1'b0;
    end
  end

  // timeout flag; set wins over a one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      response_timeout_flag <= 1'b0;
    end else if (to_hit) begin
      response_timeout_flag <= 1'b1;
    end else if (wr_en && paddr == sec_pkg::CMD_OFS &&
                 pwdata[sec_pkg::TO_BIT]) begin
      response_timeout_flag <= 1'b0;
    end
  end

  // pins as outputs or monitors when disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_memory_data_pin_out <= 1'b0;
      serial_memory_data_pin_oe <= 1'b0;
      serial_memory_clock_pin <= 1'b0;
      serial_memory_select_pin <= 1'b0;
    end else if (pin_cfg[sec_pkg::PIN_DIS_BIT]) begin
      serial_memory_data_pin_oe <= 1'b1;
      serial_memory_select_pin <= 1'b0;
      serial_memory_data_pin_out <= pin_cfg[sec_pkg::PIN_MON_BIT] ?
        media_monitor[0] : pin_cfg[sec_pkg::GPO_DATA_BIT];
      serial_memory_clock_pin <= pin_cfg[sec_pkg::PIN_MON_BIT] ?
        media_monitor[1] : pin_cfg[sec_pkg::GPO_CLK_BIT];
    end else begin
      serial_memory_data_pin_out <= ser_pins.dout;
      serial_memory_data_pin_oe <= ser_pins.oe;
      serial_memory_clock_pin <= ser_pins.sk;
      serial_memory_select_pin <= ser_pins.cs;
    end
  end
endmodule : sec_ctrl

// file: tb/sec_checker.sv
// Port checker for the serial EEPROM controller
module sec_checker #(
  parameter int TIMEOUT_CYCLES = 4000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] media_monitor,
  input wire logic serial_memory_data_pin_in,
  input wire logic serial_memory_data_pin_out,
  input wire logic serial_memory_data_pin_oe,
  input wire logic serial_memory_clock_pin,
  input wire logic serial_memory_select_pin,
  input wire logic [47:0] station_address
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic sk_q;
  logic [15:0] hcnt;
  logic [4:0] rcnt;
  logic [21:0] ccnt;
  // Cycles since clock change, rises per select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sk_q <= 1'b0;
      hcnt <= 16'h0;
      rcnt <= 5'h0;
      ccnt <= 22'h0;
    end else begin
      sk_q <= serial_memory_clock_pin;
      ccnt <= serial_memory_select_pin ? ccnt + 22'h1 : 22'h0;
      hcnt <= (serial_memory_clock_pin != sk_q) ? 16'h0 : hcnt + 16'h1;
      if (!serial_memory_select_pin)
        rcnt <= 5'h0;
      else if (serial_memory_clock_pin && !sk_q)
        rcnt <= rcnt + 5'h1;
    end
  end
  apb_ready_a:
    assert property (psel && $rose(penable) |-> pready)
      else $error("pready missing in first access cycle");
  ready_pulse_a:
    assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
  slverr_map_a:
    assert property (pready |-> pslverr ==
      !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10}))
      else $error("pslverr disagrees with address map");
  slverr_only_a:
    assert property (pslverr |-> pready)
      else $error("pslverr without pready");
  sk_half_a:
    assert property ($fell(serial_memory_clock_pin) &&
      serial_memory_select_pin |-> hcnt == 16'(sec_pkg::SK_HALF_CYCLES - 1))
      else $error("serial clock half period wrong");
  frame_len_a:
    assert property ($fell(serial_memory_select_pin) |->
      rcnt inside {5'h00, 5'h0a, 5'h12})
      else $error("serial frame clock count wrong");
  data_edge_a:
    assert property (serial_memory_select_pin && $past(serial_memory_select_pin)
      && serial_memory_data_pin_oe && $past(serial_memory_data_pin_oe) &&
      $changed(serial_memory_data_pin_out) |-> $fell(serial_memory_clock_pin))
      else $error("data changed off falling clock");
  load_start_a:
    assert property ($rose(presetn) |-> ##[1:300] serial_memory_select_pin)
      else $error("no load frame after reset");
  cs_bound_a:
    assert property (ccnt < 22'(TIMEOUT_CYCLES))
      else $error("select held past response timeout");
endmodule : sec_checker

// file: tb/sec_eeprom_model.sv
// Behavioural model of the 128-byte three-wire serial memory
module sec_eeprom_model (
  input wire logic cs,
  input wire logic sk,
  input wire logic di,
  input wire logic [31:0] busy_ns,
  output logic dout
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [128];
  logic [17:0] sr = 18'h0;
  logic [6:0] ra = 7'h00;
  logic wen = 1'b0;
  logic rd = 1'b0;
  int n = 0;
  realtime t0 = 0;
  initial dout = 1'b1;
  always @(posedge sk) if (cs) begin
    sr = {sr[16:0], di};
    n++;
    if (n == 10) begin
      ra = sr[6:0];
      casez (sr[8:5])
        4'b10??: rd = 1'b1;
        4'h3: wen = 1'b1;
        4'h0: wen = 1'b0;
        4'h2: if (wen) begin
          foreach (mem[i]) mem[i] = 8'hff;
          t0 = $realtime;
        end
        4'b11??: if (wen) begin
          mem[ra] = 8'hff;
          t0 = $realtime;
        end
        default: ;
      endcase
    end
    if (n == 18 && wen && !rd) begin
      if (sr[16:15] == 2'h1) mem[sr[14:8]] = sr[7:0];
      else foreach (mem[i]) mem[i] = sr[7:0];
      t0 = $realtime;
    end
  end
  // read byte out on falling clock
  always @(negedge sk) if (cs && rd && n < 18) dout = mem[ra][17 - n];
  // Deselected line toggles so it never looks valid
  always #10 begin
    if (!cs) begin
      n = 0;
      rd = 1'b0;
      dout = ~dout;
    end else if (!rd) dout = ($realtime >= t0 + busy_ns);
  end
endmodule : sec_eeprom_model

// file: tb/sec_ctrl_tb.sv
// Testbench for the serial EEPROM controller
module sec_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e, mdo, wen = 1'b0;
  logic [1:0] media_monitor = 2'h0;
  logic serial_memory_data_pin_in, serial_memory_data_pin_out;
  logic serial_memory_data_pin_oe, serial_memory_clock_pin;
  logic serial_memory_select_pin;
  logic [47:0] station_address, sta;
  // Op table {code, location}
  logic [9:0] ops [9] = '{10'h0ff, 10'h1ff, 10'h17f, 10'h1ff, 10'h003,
    10'h2ff, 10'h305, 10'h240, 10'h180};
  logic [7:0] ref_mem [128];
  logic [7:0] d;
  logic [31:0] busy_ns = 32'h7d0;
  int miscompares = 0, check_count = 0;
  int seed = 32'h3bd393c2;
  always #5 pclk = ~pclk;
  // Shared data wire resolved from the enable
  assign serial_memory_data_pin_in = serial_memory_data_pin_oe ?
    serial_memory_data_pin_out : mdo;
  sec_ctrl #(.TIMEOUT_CYCLES(6000)) DUT (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .media_monitor,
    .serial_memory_data_pin_in, .serial_memory_data_pin_out,
    .serial_memory_data_pin_oe, .serial_memory_clock_pin,
    .serial_memory_select_pin, .station_address);
  sec_eeprom_model M (.cs(serial_memory_select_pin),
    .sk(serial_memory_clock_pin), .di(serial_memory_data_pin_in),
    .busy_ns, .dout(mdo));
  function automatic logic [47:0] exp_sta();
    return {ref_mem[6], ref_mem[5], ref_mem[4], ref_mem[3], ref_mem[2],
      ref_mem[1]};
  endfunction : exp_sta
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t == 50) miscompares++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Polling bounded, busy may last a whole load
  task automatic idle();
    int t;
    t = 0;
    do begin
      apb(1'b0, 8'h00, 32'h0);
      t++;
    end while (r[31] !== 1'b0 && t < 9000);
    if (r[31] !== 1'b0) miscompares++;
  endtask : idle
  task automatic run(input logic [9:0] c);
    apb(1'b1, 8'h00, {1'b1, c[9:7], 21'h0, c[6:0]});
    idle();
  endtask : run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  initial begin
    #1000000;
    miscompares++;
    finish_test();
  end
  initial begin
    foreach (ref_mem[i]) ref_mem[i] = 8'($random(seed));
    ref_mem[0] = 8'ha5;
    foreach (ref_mem[i]) M.mem[i] = ref_mem[i];
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    idle();
    sta = exp_sta();
    chk(station_address, sta);
    chk(r[8], 1'b1);
    apb(1'b0, 8'h08, 32'h0);
    chk(r, sta[31:0]);
    apb(1'b0, 8'h0c, 32'h0);
    chk(r, sta[47:32]);
    apb(1'b0, 8'h14, 32'h0);
    chk(e, 1'b1);
    $display("load test done");
    foreach (ops[k]) begin
      d = 8'($random(seed));
      apb(1'b1, 8'h04, {24'h0, d});
      run(ops[k]);
      case (ops[k][9:7])
        3'h1: wen = 1'b0;
        3'h2: wen = 1'b1;
        3'h3: if (wen) ref_mem[ops[k][6:0]] = d;
        3'h4: if (wen) foreach (ref_mem[i]) ref_mem[i] = d;
        3'h5: if (wen) ref_mem[ops[k][6:0]] = 8'hff;
        3'h6: if (wen) foreach (ref_mem[i]) ref_mem[i] = 8'hff;
        default: ;
      endcase
      run({3'h0, ops[k][6:0]});
      apb(1'b0, 8'h04, 32'h0);
      chk(r[7:0], ref_mem[ops[k][6:0]]);
    end
    foreach (ref_mem[i]) chk(M.mem[i], ref_mem[i]);
    $display("command test done");
    for (int i = 0; i < 7; i++) begin
      ref_mem[i] = (i == 0) ? 8'h00 : 8'($random(seed));
      M.mem[i] = ref_mem[i];
    end
    apb(1'b1, 8'h10, 32'h100);
    idle();
    chk(r[8], 1'b0);
    chk(station_address, sta);
    M.mem[0] = 8'ha5;
    ref_mem[0] = 8'ha5;
    run(10'h380);
    chk(r[8], 1'b1);
    chk(station_address, exp_sta());
    busy_ns = 32'h3b9aca00;
    run(10'h181);
    chk({r[31], r[9]}, 2'h1);
    busy_ns = 32'h7d0;
    apb(1'b1, 8'h00, 32'h200);
    apb(1'b0, 8'h00, 32'h0);
    chk(r[9], 1'b0);
    $display("reload timeout test done");
    repeat (4) begin
      d = 8'($random(seed));
      media_monitor <= d[1:0];
      apb(1'b1, 8'h10, {28'h0, d[3:2], d[4], 1'b1});
      repeat (3) @(posedge pclk);
      #1;
      chk({serial_memory_clock_pin, serial_memory_data_pin_out,
        serial_memory_select_pin}, {d[4] ? d[1:0] : d[3:2], 1'b0});
    end
    apb(1'b1, 8'h10, 32'h0);
    $display("pin test done");
    finish_test();
  end
endmodule : sec_ctrl_tb
bind sec_ctrl sec_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk (.pclk,
  .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .media_monitor, .serial_memory_data_pin_in,
  .serial_memory_data_pin_out, .serial_memory_data_pin_oe,
  .serial_memory_clock_pin, .serial_memory_select_pin, .station_address);
